// ==== rtl/smps_socket_regs.v ====
// Socket event, mask, present-state and force event registers of one
// card socket, plus the status change interrupt.
// Assumes a simple synchronous register port and socket pin levels that
// are already synchronous to clock; card identification is done outside.
`timescale 1ns/100ps
`default_nettype none
`include "smps_map.vh"

// Overview of operation
// - Mask bits 31 to 4 read zero and ignore writes.
// - Mask only gates the interrupt; event flags always latch changes.
// - Mask bit 3 enables interrupt from power state events.
// - Mask bits 2 and 1 enable card detect interrupts; 01, 10 reserved.
// - Mask bit 0 enables interrupt from status line changes.
// - Present-state shows the forced zoomed video bit and real socket status.
// - Card voltage and type captured when identification completes, held until next.
// - Detect pin changes during identification do not update state.
// - Bits 31 and 30 read zero unless overridden.
// - Bits 29 and 28 read one unless overridden.
// - Bit 27 reports zoomed video support.
// - Present-state bits 26 to 14 read zero.
// - Bits 13 to 11 show card support of Y.Y, X.X, 3.3 V.
// - Present-state is read-only, resets to 3000_00XX.
// - Status event on both edges for 16-bit, rising for CardBus.
// - Event flags clear on write of one; zero leaves them.
// - Detect bits read one when pin high, zero when low.
module smps_socket_regs (
  // Clock and synchronous reset
  input  wire        clock,
  input  wire        reset,

  // Register port
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,

  // Socket pin levels, already synchronous
  input  wire        detect_pin_one_level,
  input  wire        detect_pin_two_level,
  input  wire        status_line_level,
  input  wire        ready_level,
  input  wire        socket_powered_flag,

  // Card identification results
  input  wire        ident_busy,
  input  wire        ident_done,
  input  wire        ident_cardbus,
  input  wire        ident_16bit,
  input  wire [2:0]  ident_volt,

  // Read data, interrupt and re-interrogation request
  output wire [31:0] reg_rdata,
  output wire        reg_rvalid,
  output wire        status_change_interrupt,
  output wire        reinterrogate_req
);

  // Register port decode
  wire wr_event;
  wire wr_mask;
  wire wr_force;
  wire wr_cap;

  // Exact decode: no aliases, so stray offsets never reach a register
  assign wr_event = reg_wr & (reg_addr == `SMPS_OFS_EVENT);
  assign wr_mask  = reg_wr & (reg_addr == `SMPS_OFS_MASK);
  assign wr_force = reg_wr & (reg_addr == `SMPS_OFS_FORCE);
  assign wr_cap   = reg_wr & (reg_addr == `SMPS_OFS_CAP);

  // Mask register
  reg [`SMPS_EVT_W-1:0] irq_enable_ff;
  wire power_event_irq_enable;
  wire [1:0] card_detect_irq_enable;
  wire status_line_irq_enable;

  always @(posedge clock) begin
    if (reset) begin
      irq_enable_ff <= `SMPS_MASK_RST;
    end else if (wr_mask) begin
      irq_enable_ff <= reg_wdata[`SMPS_EVT_W-1:0];
    end
  end

  assign power_event_irq_enable = irq_enable_ff[`SMPS_EVT_PWR];
  // Patterns 01 and 10 are reserved; here each bit gates its own detect pin
  assign card_detect_irq_enable = irq_enable_ff[`SMPS_EVT_CD2:`SMPS_EVT_CD1];
  assign status_line_irq_enable = irq_enable_ff[`SMPS_EVT_STS];

  // Socket capability and zoomed video, overridable by software
  // The override register lets software hide a supply the board lacks
  reg [3:0] sock_cap_ff;
  reg       zoomed_video_capable_ff;

  always @(posedge clock) begin
    if (reset) begin
      sock_cap_ff <= `SMPS_CAP_RST;
    end else if (wr_cap) begin
      sock_cap_ff <= reg_wdata[`SMPS_PS_CAP_HI:`SMPS_PS_CAP_LO];
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      zoomed_video_capable_ff <= `SMPS_ZV_RST;
    end else if (wr_force) begin
      zoomed_video_capable_ff <= reg_wdata[`SMPS_FRC_ZV];
    end
  end

  // Card identity, captured only when identification completes
  // Removal leaves it alone, so software can still see the last card
  reg [2:0] card_volt_ff;
  reg       cardbus_card_ff;
  reg       bit16_card_ff;

  always @(posedge clock) begin
    if (reset) begin
      card_volt_ff    <= `SMPS_CVOLT_RST;
      cardbus_card_ff <= 1'h0;
      bit16_card_ff   <= 1'h0;
    end else if (ident_done) begin
      card_volt_ff    <= ident_volt;
      cardbus_card_ff <= ident_cardbus;
      bit16_card_ff   <= ident_16bit;
    end
  end

  // Re-interrogation request from the force register, one-cycle pulse
  // Only a request; the identification logic outside does the work
  reg reinterrogate_ff;

  always @(posedge clock) begin
    if (reset) begin
      reinterrogate_ff <= 1'h0;
    end else begin
      reinterrogate_ff <= wr_force & reg_wdata[`SMPS_FRC_VSTEST];
    end
  end

  // Live socket levels
  reg detect_one_ff;
  reg detect_two_ff;
  reg status_line_ff;
  reg ready_ff;
  reg powered_ff;

  // Reset to the no-card levels, so a card present at reset gives an event
  wire [`SMPS_EVT_W-1:0] live_rst;

  assign live_rst = `SMPS_LIVE_RST;

  always @(posedge clock) begin
    if (reset) begin
      detect_one_ff <= live_rst[`SMPS_EVT_CD1];
      detect_two_ff <= live_rst[`SMPS_EVT_CD2];
    end else if (!ident_busy) begin
      detect_one_ff <= detect_pin_one_level;
      detect_two_ff <= detect_pin_two_level;
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      status_line_ff <= live_rst[`SMPS_EVT_STS];
      ready_ff       <= 1'h0;
      powered_ff     <= live_rst[`SMPS_EVT_PWR];
    end else begin
      status_line_ff <= status_line_level;
      ready_ff       <= ready_level;
      powered_ff     <= socket_powered_flag;
    end
  end

  // Present-state word
  wire [31:0] present_word;
  wire [`SMPS_EVT_W-1:0] monitored;

  assign monitored = {powered_ff, detect_two_ff, detect_one_ff, status_line_ff};

  assign present_word = {sock_cap_ff,
                         zoomed_video_capable_ff,
                         13'h0000,
                         card_volt_ff,
                         4'h0,
                         ready_ff,
                         cardbus_card_ff,
                         bit16_card_ff,
                         monitored};

  // Event detection and flags
  wire [`SMPS_EVT_W-1:0] changed;
  wire [`SMPS_EVT_W-1:0] force_set;
  wire [`SMPS_EVT_W-1:0] clear_set;
  wire [`SMPS_EVT_W-1:0] event_flags;

  smps_change_detect u_detect (
    .clock        (clock),
    .reset        (reset),
    .level        (monitored),
    .cardbus_card (cardbus_card_ff),
    .changed      (changed)
  );

  // Forced events share the set path, so they behave like real ones
  assign force_set = wr_force ? reg_wdata[`SMPS_EVT_W-1:0] : `SMPS_EVT_RST;
  assign clear_set = wr_event ? reg_wdata[`SMPS_EVT_W-1:0] : `SMPS_EVT_RST;

  smps_event_flags u_flags (
    .clock   (clock),
    .reset   (reset),
    .set_evt (changed | force_set),
    .clr_evt (clear_set),
    .flags   (event_flags)
  );

  // Status change interrupt
  reg  irq_ff;
  wire irq_pwr;
  wire irq_cd;
  wire irq_sts;

  assign irq_pwr = power_event_irq_enable & event_flags[`SMPS_EVT_PWR];
  assign irq_cd = |(card_detect_irq_enable &
                    event_flags[`SMPS_EVT_CD2:`SMPS_EVT_CD1]);
  assign irq_sts = status_line_irq_enable & event_flags[`SMPS_EVT_STS];

  // Registered, so the interrupt lags its flag by one cycle
  // level interrupt
  always @(posedge clock) begin
    if (reset) begin
      irq_ff <= 1'h0;
    end else begin
      irq_ff <= irq_pwr | irq_cd | irq_sts;
    end
  end

  // Read path, data one cycle after the strobe
  reg [31:0] rdata_ff;
  reg        rvalid_ff;
  reg [31:0] nxt_rdata;

  always @* begin
    nxt_rdata = `SMPS_ZERO32;
    case (reg_addr)
      `SMPS_OFS_EVENT: begin
        nxt_rdata[`SMPS_EVT_W-1:0] = event_flags;
      end
      `SMPS_OFS_MASK: begin
        nxt_rdata[`SMPS_EVT_W-1:0] = irq_enable_ff;
      end
      `SMPS_OFS_PRESENT: begin
        nxt_rdata = present_word;
      end
      `SMPS_OFS_CAP: begin
        nxt_rdata[`SMPS_PS_CAP_HI:`SMPS_PS_CAP_LO] = sock_cap_ff;
      end
      // The force register is write-only and reads back as zero
      default: begin
        nxt_rdata = `SMPS_ZERO32;
      end
    endcase
  end

  always @(posedge clock) begin
    if (reset) begin
      rdata_ff  <= `SMPS_ZERO32;
      rvalid_ff <= 1'h0;
    end else begin
      rvalid_ff <= reg_rd;
      if (reg_rd) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign reg_rdata               = rdata_ff;
  assign reg_rvalid              = rvalid_ff;
  assign status_change_interrupt = irq_ff;
  assign reinterrogate_req       = reinterrogate_ff;

endmodule // smps_socket_regs
`default_nettype wire

// ==== rtl/smps_map.vh ====
// Register map, field positions and reset values of the socket mask and
// present-state block. Definitions only; included by the design files.
`ifndef SMPS_MAP_VH
`define SMPS_MAP_VH

// Register offsets (byte addresses)
`define SMPS_OFS_EVENT      8'h00
`define SMPS_OFS_MASK       8'h04
`define SMPS_OFS_PRESENT    8'h08
`define SMPS_OFS_FORCE      8'h0c
`define SMPS_OFS_CAP        8'h24

// Event and mask bit positions
`define SMPS_EVT_W          4
`define SMPS_EVT_STS        0
`define SMPS_EVT_CD1        1
`define SMPS_EVT_CD2        2
`define SMPS_EVT_PWR        3

// Force event fields
`define SMPS_FRC_ZV         27
`define SMPS_FRC_VSTEST     14

// Present-state fields
`define SMPS_PS_CAP_HI      31
`define SMPS_PS_CAP_LO      28
`define SMPS_PS_ZV          27
`define SMPS_PS_CVOLT_HI    13
`define SMPS_PS_CVOLT_LO    11
`define SMPS_PS_READY       6
`define SMPS_PS_CB          5
`define SMPS_PS_16          4

// Reset values
`define SMPS_MASK_RST       4'h0
`define SMPS_EVT_RST        4'h0
`define SMPS_CAP_RST        4'h3
`define SMPS_ZV_RST         1'h0
`define SMPS_CVOLT_RST      3'h0
`define SMPS_LIVE_RST       4'h6
`define SMPS_ZERO32         32'h0000_0000

`endif

// ==== rtl/smps_event_flags.v ====
// Sticky socket event flags, one per monitored condition.
// Assumes set and clear strobes are synchronous to clock.
`timescale 1ns/100ps
`default_nettype none
`include "smps_map.vh"

module smps_event_flags (
  input  wire                   clock,
  input  wire                   reset,
  input  wire [`SMPS_EVT_W-1:0] set_evt,
  input  wire [`SMPS_EVT_W-1:0] clr_evt,
  output wire [`SMPS_EVT_W-1:0] flags
);

  reg [`SMPS_EVT_W-1:0] flag_ff;

  genvar i;
  generate
    for (i = 0; i < `SMPS_EVT_W; i = i + 1) begin : g_flag
      // write one clears
      // Set beats clear so an event in the clear cycle survives
      always @(posedge clock) begin
        if (reset) begin
          flag_ff[i] <= 1'h0;
        end else begin
          flag_ff[i] <= set_evt[i] | (flag_ff[i] & ~clr_evt[i]);
        end
      end
    end
  endgenerate

  assign flags = flag_ff;

endmodule // smps_event_flags
`default_nettype wire

// ==== rtl/smps_change_detect.v ====
// Change detector for present-state bits 3..0 that feed the event flags.
// Assumes the monitored levels are already registered.
`timescale 1ns/100ps
`default_nettype none
`include "smps_map.vh"

module smps_change_detect (
  input  wire                   clock,
  input  wire                   reset,
  input  wire [`SMPS_EVT_W-1:0] level,
  input  wire                   cardbus_card,
  output wire [`SMPS_EVT_W-1:0] changed
);

  reg  [`SMPS_EVT_W-1:0] prev_ff;
  reg                    armed_ff;
  wire [`SMPS_EVT_W-1:0] rise;
  wire [`SMPS_EVT_W-1:0] fall;

  // No events until a first real sample has been taken after reset
  always @(posedge clock) begin
    if (reset) begin
      prev_ff  <= `SMPS_LIVE_RST;
      armed_ff <= 1'h0;
    end else begin
      prev_ff  <= level;
      armed_ff <= 1'h1;
    end
  end

  genvar i;
  generate
    for (i = 0; i < `SMPS_EVT_W; i = i + 1) begin : g_edge
      assign rise[i] = armed_ff & level[i] & ~prev_ff[i];
      assign fall[i] = armed_ff & ~level[i] & prev_ff[i];
      if (i == `SMPS_EVT_STS) begin : g_sts
        assign changed[i] = rise[i] | (fall[i] & ~cardbus_card);
      end else begin : g_any
        assign changed[i] = rise[i] | fall[i];
      end
    end
  endgenerate

endmodule // smps_change_detect
`default_nettype wire

// ==== verification/smps_properties.sv ====
// Checker of the register port, live socket bits and interrupt.
// Assumes it is bound to smps_socket_regs and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module smps_properties (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        detect_pin_one_level,
  input wire logic        detect_pin_two_level,
  input wire logic        status_line_level,
  input wire logic        ready_level,
  input wire logic        ident_busy,
  input wire logic [31:0] reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic        status_change_interrupt,
  input wire logic        reinterrogate_req
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // Present word at a read is the pins sampled one edge earlier
  sequence s_rd_ps;
    reg_rd && reg_addr == 8'h08 && !$past(reset);
  endsequence
  sequence s_force_zv;
    reg_wr && reg_addr == 8'h0c && reg_wdata[27];
  endsequence
  chk_rvalid_after_read:
    assert property (reg_rd |=> reg_rvalid) else $error("No read valid after read");
  chk_rvalid_one_pulse:
    assert property (!reg_rd |=> !reg_rvalid) else $error("Read valid without read");
  chk_mask_rsvd_zero:
    assert property (reg_rd && reg_addr == 8'h04 |=> reg_rdata[31:4] == 28'h000_0000)
      else $error("Mask upper bits not zero");
  chk_present_rsvd_zero:
    assert property (s_rd_ps |=> reg_rdata[26:14] == 13'h0000)
      else $error("Present reserved bits not zero");
  chk_live_pin_bits:
    assert property (s_rd_ps |=> reg_rdata[6] == $past(ready_level, 2) &&
      reg_rdata[0] == $past(status_line_level, 2)) else $error("Live pin bits wrong");
  chk_detect_pin_bits:
    assert property (s_rd_ps ##0 !$past(ident_busy) |=> reg_rdata[2:1] ==
      {$past(detect_pin_two_level, 2), $past(detect_pin_one_level, 2)})
      else $error("Detect bits wrong");
  chk_irq_mask_zero:
    assert property (reg_wr && reg_addr == 8'h04 && reg_wdata[3:0] == 4'h0 |=> ##1
      !status_change_interrupt) else $error("Interrupt with mask cleared");
  chk_vs_test_pulse:
    assert property (reg_wr && reg_addr == 8'h0c && reg_wdata[14] |=> reinterrogate_req)
      else $error("No reinterrogate pulse");
  chk_zv_force_seen:
    assert property (s_force_zv ##2 s_rd_ps |=> reg_rdata[27])
      else $error("Forced zoomed video not shown");
endmodule // smps_properties
`default_nettype wire

// ==== verification/smps_card_model.sv ====
// Card in the socket: detect pins, status line, ready and identification.
// Assumes bench commands change just after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module smps_card_model (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       insert,
  input  wire logic       sts_cmd,
  input  wire logic       cb_cmd,
  input  wire logic [2:0] volt_cmd,
  output wire logic       detect_pin_one_level,
  output wire logic       detect_pin_two_level,
  output wire logic       status_line_level,
  output wire logic       ready_level,
  output wire logic       ident_busy,
  output wire logic       ident_done,
  output wire logic       ident_cardbus,
  output wire logic       ident_16bit,
  output wire logic [2:0] ident_volt
);
  logic [2:0] cnt_ff;
  logic       ins_ff;
  // Identification runs six cycles after the card lands
  always @(posedge clock) begin
    ins_ff <= insert;
    if (reset)
      cnt_ff <= 3'h0;
    else if (insert && !ins_ff)
      cnt_ff <= 3'h6;
    else if (cnt_ff != 3'h0)
      cnt_ff <= cnt_ff - 3'h1;
  end
  assign ident_busy = cnt_ff != 3'h0;
  assign ident_done = cnt_ff == 3'h1;
  // Pins pulled up with no card; pin two bounces while identifying
  assign detect_pin_one_level = !insert;
  assign detect_pin_two_level = insert ? (ident_busy & ~cnt_ff[0]) : 1'h1;
  assign status_line_level = insert & sts_cmd;
  assign ready_level = insert & !ident_busy;
  // Type and voltage are garbage outside the done pulse
  assign ident_cardbus = ident_done ? cb_cmd : !cb_cmd;
  assign ident_16bit = ident_done ? !cb_cmd : cb_cmd;
  assign ident_volt = ident_done ? volt_cmd : ~volt_cmd;
endmodule // smps_card_model
`default_nettype wire

// ==== verification/smps_socket_regs_tb.sv ====
// Self-checking bench of the socket mask and present-state registers.
// Assumes the card model drives the socket pins and identification.
`timescale 1ns/100ps
`default_nettype none
module smps_socket_regs_tb;
  logic        clock, reset, reg_wr, reg_rd, insert, sts_cmd, cb_cmd, powered;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic [2:0]  volt_cmd;
  wire         p1, p2, sts, rdy, busy, done, icb, i16, irq, rvalid, reint;
  wire  [2:0]  ivolt;
  wire  [31:0] reg_rdata;
  int          n_mismatch, n_tests;
  smps_card_model card (.clock(clock), .reset(reset), .insert(insert), .sts_cmd(sts_cmd),
    .cb_cmd(cb_cmd), .volt_cmd(volt_cmd), .detect_pin_one_level(p1),
    .detect_pin_two_level(p2), .status_line_level(sts), .ready_level(rdy),
    .ident_busy(busy), .ident_done(done), .ident_cardbus(icb), .ident_16bit(i16),
    .ident_volt(ivolt));
  smps_socket_regs dut (.clock(clock), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .detect_pin_one_level(p1),
    .detect_pin_two_level(p2), .status_line_level(sts), .ready_level(rdy),
    .socket_powered_flag(powered), .ident_busy(busy), .ident_done(done),
    .ident_cardbus(icb), .ident_16bit(i16), .ident_volt(ivolt), .reg_rdata(reg_rdata),
    .reg_rvalid(rvalid), .status_change_interrupt(irq), .reinterrogate_req(reint));
  task results();
    $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0d ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr    <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'h0;
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e);
    int k;
    k = 0;
    @(posedge clock);
    reg_rd   <= 1'h1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'h0;
    #1;
    while (rvalid !== 1'h1 && k < 4) begin
      @(posedge clock);
      #1;
      k++;
    end
    if (rvalid !== 1'h1) begin
      n_mismatch++;
      $display("[ERR] %0d ns: no read answer", $time);
      results();
    end else
      chk(reg_rdata, e);
  endtask
  // Waits past the three-edge pin change to interrupt latency
  task settle(input logic exp_irq);
    repeat (3) @(posedge clock);
    #1;
    chk({31'h0000_0000, irq}, {31'h0000_0000, exp_irq});
  endtask
  initial begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end
  initial begin
    {reset, reg_wr, reg_rd, reg_addr, reg_wdata, powered} = {1'h1, 43'h000_0000_0000};
    {insert, sts_cmd, cb_cmd, volt_cmd} = 6'h00;
    n_mismatch = 0;
    n_tests = 0;
    repeat (3) @(posedge clock);
    reset <= 1'h0;
    rc(8'h04, 32'h0000_0000);
    wr(8'h08, 32'hffff_ffff);
    rc(8'h08, 32'h3000_0006);
    rc(8'h14, 32'h0000_0000);
    wr(8'h04, 32'hffff_ffff);
    rc(8'h04, 32'h0000_000f);
    wr(8'h04, 32'h0000_0000);
    $display("Test reset and mask done");
    @(posedge clock);
    {insert, volt_cmd} <= 4'hd;
    repeat (3) @(posedge clock);
    rc(8'h08, 32'h3000_0000);
    repeat (8) @(posedge clock);
    rc(8'h08, 32'h3000_2850);
    rc(8'h00, 32'h0000_0006);
    settle(1'h0);
    wr(8'h00, 32'h0000_0000);
    rc(8'h00, 32'h0000_0006);
    wr(8'h04, 32'h0000_0006);
    settle(1'h1);
    wr(8'h00, 32'h0000_0006);
    settle(1'h0);
    $display("Test insertion done");
    wr(8'h04, 32'h0000_0001);
    sts_cmd <= 1'h1;
    settle(1'h1);
    wr(8'h00, 32'h0000_0001);
    sts_cmd <= 1'h0;
    settle(1'h1);
    wr(8'h00, 32'h0000_0001);
    {insert, cb_cmd, volt_cmd} <= 5'h0a;
    settle(1'h0);
    rc(8'h08, 32'h3000_2816);
    @(posedge clock);
    insert <= 1'h1;
    repeat (11) @(posedge clock);
    rc(8'h08, 32'h3000_1060);
    wr(8'h00, 32'h0000_000f);
    sts_cmd <= 1'h1;
    settle(1'h1);
    wr(8'h00, 32'h0000_000f);
    sts_cmd <= 1'h0;
    settle(1'h0);
    $display("Test status line done");
    wr(8'h04, 32'h0000_0000);
    powered <= 1'h1;
    settle(1'h0);
    rc(8'h00, 32'h0000_0008);
    wr(8'h04, 32'h0000_0008);
    settle(1'h1);
    wr(8'h0c, 32'h0800_4000);
    rc(8'h08, 32'h3800_1068);
    wr(8'h0c, 32'h0000_0001);
    rc(8'h00, 32'h0000_0009);
    wr(8'h24, 32'hc000_0000);
    rc(8'h08, 32'hc000_1068);
    rc(8'h24, 32'hc000_0000);
    $display("Test power and force done");
    @(posedge clock);
    reset <= 1'h1;
    repeat (3) @(posedge clock);
    reset <= 1'h0;
    rc(8'h04, 32'h0000_0000);
    rc(8'h08, 32'h3000_0048);
    settle(1'h0);
    $display("Test mid-run reset done");
    results();
  end
endmodule // smps_socket_regs_tb
bind smps_socket_regs smps_properties u_chk (.clock(clock), .reset(reset), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .ready_level(ready_level),
  .detect_pin_one_level(detect_pin_one_level), .detect_pin_two_level(detect_pin_two_level),
  .status_line_level(status_line_level), .ident_busy(ident_busy), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .status_change_interrupt(status_change_interrupt),
  .reinterrogate_req(reinterrogate_req));
`default_nettype wire
